// ### bench/lane_tx_model.sv
/* Far transmitter: reports lane sync some cycles after links enable. */
`timescale 1ns/100ps
module lane_tx_model #(parameter int DELAY = 20) (
    input wire logic       clk_i,     // clock
    input wire logic       rst_i,     // reset
    input wire logic       link_en_i, // links enabled
    input wire logic       drop_i,    // lose lane 0
    output logic     [7:0] sync_o     // lane status
);
    int n;
    // Already ready, so sync follows the enable after a fixed delay.
    always @(posedge clk_i) n <= (rst_i || !link_en_i) ? 0 : (n < DELAY ? n + 1 : n);
    assign sync_o = (n == DELAY) ? {7'h7f, !drop_i} : 8'h00;
endmodule

// ### bench/link_bringup_props.sv
/* Port checker for link_bringup. Assumes it is bound to the top module. */
`timescale 1ns/100ps
module link_bringup_props import bringup_pkg::*; (
    input wire logic       core_clk_i,      // clock
    input wire logic       rst_i,           // reset
    input wire logic       csn_i,           // select
    input wire logic [7:0] lane_pd_o,       // lanes
    input wire logic       descramble_o,    // descramble
    input wire logic [2:0] subclass_o,      // class
    input wire logic       tcal_first_o,    // cal 1
    input wire logic       tcal_second_o,   // cal 2
    input wire logic       link_up_o,       // running
    input wire logic       link_enable_o,   // links on
    input wire logic       pll_enable_o,    // pll on
    input wire logic       serdes_enable_o, // powered
    input wire logic       deframer_rst_o   // deframer held
);
    // ====
    // Assertions
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    a_reset_state: assert property ($fell(rst_i) |-> !serdes_enable_o && deframer_rst_o)
        else $error("wrong state after reset");
    a_up_link: assert property (link_up_o |-> link_enable_o && pll_enable_o
        && serdes_enable_o) else $error("link up without enables");
    a_up_deframer: assert property (link_up_o |-> !deframer_rst_o)
        else $error("link up with deframer held");
    a_link_drop: assert property (!link_enable_o [*3] |-> !link_up_o)
        else $error("link up while disabled");
    a_cal_pulse: assert property (tcal_first_o |=> !tcal_first_o)
        else $error("calibration pulse too long");
    a_cal_idle: assert property (csn_i [*8] |-> !(tcal_first_o || tcal_second_o))
        else $error("calibration without write");
    a_lane_quiet: assert property (csn_i [*8] |-> $stable(lane_pd_o))
        else $error("lane power changed unasked");
    a_param_quiet: assert property (csn_i [*8] |-> $stable({descramble_o, subclass_o}))
        else $error("link parameter changed unasked");
    cover property ($rose(link_up_o));
    cover property (tcal_second_o);
    cover property ($fell(deframer_rst_o));
endmodule
bind link_bringup link_bringup_props link_bringup_props_inst (.*);

// ### bench/testbench.sv
/* Bench for link_bringup. Assumes the far transmitter model beside it. */
`timescale 1ns/100ps
module testbench import bringup_pkg::*;;
    logic core_clk_i, rst_i, sclk_i, csn_i, mosi_i, pll_locked_i, drop, miso_o, miso_oe_o;
    logic serdes_enable_o, cdr_enable_o, pll_enable_o, tcal_first_o, tcal_second_o;
    logic deframer_rst_o, descramble_o, link_enable_o, link_up_o, inverse_sinc_enable_o;
    logic oscillator_mix_enable_o, filter_bandwidth_select_o, fractional_modulus_enable_o;
    logic sideband_select_o, half_band_interp_enable_o;
    logic [1:0] pll_div_o, pll_ref_rate_o;
    logic [2:0] subclass_o, version_o;
    logic [4:0] irq_event_i;
    logic [7:0] lane_pd_o, cdr_rate_o, pll_override_o, checksum_o, sync, e;
    logic [7:0] lane_cgs_i, lane_fs_i, lane_cks_i, lane_ils_i, m [int];
    logic [11:0] ra [6] = '{A_DP_OPTS, A_CDR_RATE, A_PLL_DIV, A_PLL_REF, A_SCRAMBLE, A_CHECKSUM};
    int err_count = 0, check_count = 0, ncal [2] = '{0, 0};
    assign {lane_cgs_i, lane_fs_i, lane_cks_i, lane_ils_i} = {4{sync}};
    link_bringup link_bringup_inst (.*);
    lane_tx_model #(.DELAY(20)) lane_tx_model_inst (.clk_i(core_clk_i), .rst_i(rst_i),
        .link_en_i(link_enable_o), .drop_i(drop), .sync_o(sync));
    task automatic xfer(input logic [15:0] ins, input logic [7:0] wd, output logic [7:0] rd);
        logic [23:0] w;
        w = {ins, wd};
        csn_i <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        for (int i = 23; i >= 0; i--) begin
            sclk_i <= 1'b0;
            mosi_i <= w[i];
            repeat (8) @(posedge core_clk_i);
            rd = {rd[6:0], miso_oe_o ? miso_o : 1'b1};
            sclk_i <= 1'b1;
            repeat (8) @(posedge core_clk_i);
        end
        sclk_i <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        csn_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        logic [7:0] t;
        xfer({4'h0, a}, v, t);
        m[a] = v;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] v;
        xfer({4'h8, a}, 8'h00, v);
        check(v, exp);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        if (tcal_first_o === 1'b1) ncal[0]++;
        if (tcal_second_o === 1'b1) ncal[1]++;
    end
    initial begin
        repeat (60000) @(posedge core_clk_i);
        err_count++;
        finish_test();
    end
    initial begin
        {rst_i, csn_i, sclk_i, mosi_i, pll_locked_i, drop, irq_event_i} = {2'b11, 9'h0};
        e = 8'($urandom(32'hf532));
        repeat (12) @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        rchk(A_MASTER_PWR, 8'h01);
        rchk(A_DFR_RESET, 8'h09);
        wr(A_LINK_EN, 8'h00);
        wr(12'h110, 8'h24);
        rchk(12'h110, 8'h00);
        foreach (ra[i]) wr(ra[i], 8'($urandom) & (i ? 8'hff : DP_WR_MASK));
        e = m[A_DP_OPTS];
        rchk(A_DP_OPTS, e & 8'hd7);
        check({inverse_sinc_enable_o, oscillator_mix_enable_o, filter_bandwidth_select_o,
            fractional_modulus_enable_o, sideband_select_o, half_band_interp_enable_o, 2'b0},
            {e[7:6], e[4], e[2:0], 2'b0});
        check(cdr_rate_o, m[A_CDR_RATE]);
        check({6'h0, pll_div_o}, {6'h0, m[A_PLL_DIV][1:0]});
        check({6'h0, pll_ref_rate_o}, {6'h0, m[A_PLL_REF][5:4]});
        check({7'h0, descramble_o}, {7'h0, m[A_SCRAMBLE][7]});
        rchk(A_CHECKSUM, m[A_CHECKSUM]);
        check(checksum_o, m[A_CHECKSUM]);
        wr(A_MASTER_PWR, 8'h00);
        check({7'h0, serdes_enable_o}, 8'h01);
        for (int s = 1; s >= 0; s--) begin
            wr(A_SUBCLASS, {3'(s), 5'h0});
            check({5'h0, subclass_o}, 8'(s));
        end
        wr(A_VERSION, 8'h20);
        check({5'h0, version_o}, 8'h01);
        wr(A_DFR_RESET, 8'h01);
        check({7'h0, deframer_rst_o}, 8'h00);
        wr(A_LANE_PD, 8'($urandom) & 8'hfe);
        check(lane_pd_o, m[A_LANE_PD]);
        for (int k = 0; k < 2; k++) begin
            wr(k ? A_TCAL_SECOND : A_TCAL_FIRST, 8'h02);
            wr(k ? A_TCAL_SECOND : A_TCAL_FIRST, 8'h01);
            check(8'(ncal[k]), 8'h01);
        end
        wr(A_PLL_OVR, 8'h1f);
        check(pll_override_o, 8'h1f);
        for (int k = 0; k < 2; k++) begin
            wr(A_CDR_CTL, 8'(k));
            check({7'h0, cdr_enable_o}, 8'(k));
        end
        wr(A_PLL_CTL, 8'h03);
        check({7'h0, pll_enable_o}, 8'h01);
        rchk(A_PLL_STAT, 8'h00);
        pll_locked_i <= 1'b1;
        rchk(A_PLL_STAT, 8'h01);
        wr(A_LINK_EN, 8'h01);
        for (int n = 0; n < 300 && link_up_o !== 1'b1; n++) @(posedge core_clk_i);
        check({7'h0, link_up_o}, 8'h01);
        for (int k = 0; k < 4; k++) rchk(A_CGS_STAT + 12'(k), ~m[A_LANE_PD]);
        e = 8'($urandom) | 8'h01;
        irq_event_i <= e[4:0];
        @(posedge core_clk_i);
        irq_event_i <= 5'h0;
        rchk(A_IRQ_STATUS, {3'h0, e[4:0]});
        wr(A_IRQ_STATUS, 8'h1f);
        rchk(A_IRQ_STATUS, 8'h00);
        drop <= 1'b1;
        repeat (10) @(posedge core_clk_i);
        for (int k = 0; k < 2; k++) begin
            rchk(A_SIRQ_FIRST + 12'(k), 8'h01);
            wr(A_SIRQ_FIRST + 12'(k), k ? 8'h01 : 8'hff);
            rchk(A_SIRQ_FIRST + 12'(k), 8'h00);
        end
        finish_test();
    end
endmodule

// ### common/bringup_pkg.sv
/*
 * Start-up block constants: addresses, fields, commands, reset values.
 * Assumes 12-bit addresses and 8-bit registers.
 */
package bringup_pkg;
    localparam int          NUM_LANES     = 8;
    localparam int          ADDR_W        = 12;
    localparam int          INSTR_W       = 16;
    localparam int          DATA_W        = 8;
    // ====
    // Register addresses
    localparam logic [11:0] A_IRQ_STATUS  = 12'h024;
    localparam logic [11:0] A_PLL_REF     = 12'h084;
    localparam logic [11:0] A_DP_OPTS     = 12'h111;
    localparam logic [11:0] A_MASTER_PWR  = 12'h200;
    localparam logic [11:0] A_LANE_PD     = 12'h201;
    localparam logic [11:0] A_CDR_CTL     = 12'h206;
    localparam logic [11:0] A_CDR_RATE    = 12'h230;
    localparam logic [11:0] A_PLL_CTL     = 12'h280;
    localparam logic [11:0] A_PLL_STAT    = 12'h281;
    localparam logic [11:0] A_PLL_DIV     = 12'h289;
    localparam logic [11:0] A_PLL_OVR     = 12'h29e;
    localparam logic [11:0] A_TCAL_FIRST  = 12'h2a7;
    localparam logic [11:0] A_TCAL_SECOND = 12'h2ae;
    localparam logic [11:0] A_LINK_EN     = 12'h300;
    localparam logic [11:0] A_SCRAMBLE    = 12'h453;
    localparam logic [11:0] A_SUBCLASS    = 12'h458;
    localparam logic [11:0] A_VERSION     = 12'h459;
    localparam logic [11:0] A_CHECKSUM    = 12'h45d;
    localparam logic [11:0] A_CGS_STAT    = 12'h470;
    localparam logic [11:0] A_FS_STAT     = 12'h471;
    localparam logic [11:0] A_CKS_STAT    = 12'h472;
    localparam logic [11:0] A_ILS_STAT    = 12'h473;
    localparam logic [11:0] A_DFR_RESET   = 12'h475;
    localparam logic [11:0] A_SIRQ_FIRST  = 12'h4ba;
    localparam logic [11:0] A_SIRQ_SECOND = 12'h4bb;
    // ====
    // Fields and commands
    localparam logic [7:0]  DP_WR_MASK    = 8'hd7;
    localparam int          DP_INVSINC    = 7;
    localparam int          DP_OSC        = 6;
    localparam int          DP_FILTER_BANDWIDTH_SELECT    = 4;
    localparam int          DP_MODULUS    = 2;
    localparam int          DP_SIDEBAND   = 1;
    localparam int          DP_HB_INTERP  = 0;
    localparam int          FLD3_LSB      = 5;
    localparam int          FLD2_LSB      = 4;
    localparam int          DFR_RST_BIT   = 3;
    localparam int          SCRAMBLE_BIT  = 7;
    localparam int          IRQ_W         = 5;
    localparam logic [7:0]  PLL_ENABLE    = 8'h03;
    localparam logic [7:0]  CMD_ONE       = 8'h01;
    localparam logic [7:0]  POWER_ON      = 8'h00;
    // ====
    // Reset values
    localparam logic [7:0]  RST_MASTER    = 8'h01;
    localparam logic [7:0]  RST_DFR       = 8'h09;
    localparam logic [7:0]  RST_ZERO      = 8'h00;
endpackage

// ### verilog/cfg_serial_port.sv
/*
 * Serial configuration port: read flag, 12-bit address in the low bits of a 15-bit field, one data byte,
 * MSB first, mode 0. Assumes sclk_i below one eighth of core_clk_i.
 */
`timescale 1ns/100ps
module cfg_serial_port import bringup_pkg::*; (
    input  wire logic              core_clk_i,  // core clock
    input  wire logic              rst_i,       // synchronous reset
    input  wire logic              sclk_i,      // serial clock pin
    input  wire logic              csn_i,       // chip select, active low
    input  wire logic              mosi_i,      // serial data in
    output logic                   miso_o,      // serial data out
    output logic                   miso_oe_o,   // serial out enable
    output logic [ADDR_W-1:0]      addr_o,      // register address
    output logic [DATA_W-1:0]      wdata_o,     // write data
    output logic                   wr_o,        // write strobe, one cycle
    input  wire logic [DATA_W-1:0] rdata_i      // read data for addr_o
);
    typedef struct packed {
        logic [2:0]         sclk;
        logic [1:0]         csn;
        logic [1:0]         mosi;
        logic [4:0]         cnt;
        logic [15:0]        sh;
        logic               rd;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  tx;
        logic [DATA_W-1:0]  wdata;
        logic               wr;
    } port_t;

    port_t q;
    port_t n;
    logic  rise;
    logic  fall;

    // ====
    // Edge detection reads only the second and third synchroniser stages.
    assign rise = q.sclk[1] & ~q.sclk[2];
    assign fall = ~q.sclk[1] & q.sclk[2];

    always_comb begin
        n      = q;
        n.sclk = {q.sclk[1:0], sclk_i};
        n.csn  = {q.csn[0], csn_i};
        n.mosi = {q.mosi[0], mosi_i};
        n.wr   = 1'b0;
        if (q.csn[1]) begin
            n.cnt = '0;
        end else if (rise) begin
            n.sh  = {q.sh[14:0], q.mosi[1]};
            n.cnt = q.cnt + 5'h01;
            if (q.cnt == 5'(INSTR_W - 1)) begin
                n.rd   = q.sh[14];
                n.addr = {q.sh[ADDR_W-2:0], q.mosi[1]};
            end
            if (q.cnt == 5'(INSTR_W + DATA_W - 1) && !q.rd) begin
                n.wdata = {q.sh[DATA_W-2:0], q.mosi[1]};
                n.wr    = 1'b1;
            end
        end else if (fall && q.rd) begin
            if (q.cnt == 5'(INSTR_W)) begin
                n.tx = rdata_i;
            end else if (q.cnt > 5'(INSTR_W)) begin
                n.tx = {q.tx[DATA_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            q      <= '0;
            q.csn  <= 2'h3;
        end else begin
            q <= n;
        end
    end

    assign miso_o    = q.tx[DATA_W-1];
    assign miso_oe_o = ~q.csn[1] & q.rd & (q.cnt >= 5'(INSTR_W));
    assign addr_o    = q.addr;
    assign wdata_o   = q.wdata;
    assign wr_o      = q.wr;
endmodule

// ### verilog/link_bringup.sv
/*
 * Register file and start-up control of an eight-lane receive link.
 * Assumes lane status and PLL lock are asynchronous, events on core_clk_i.
 */
//
// Behaviour
// R01: Host sets datapath option bits, reserved zero
// R02: Host sets recovery half-rate and divider
// R03: Host sets two-bit PLL divider first
// R04: Host sets reference rate in bits 5:4
// R05: Master power zero enables the block
// R06: 0x09 holds the deframer in reset
// R07: Bit 7 enables lane descrambling
// R08: Subclass field: 000 class 0, 001 class 1
// R09: Host sets version field to serial-link mode
// R10: Host writes lane 0 configuration checksum
// R11: 0x01 releases the deframer
// R12: Each lane power bit powers down lane
// R13: 0x01 starts termination calibration
// R14: Host writes 0x1F PLL override first
// R15: 0x03 enables the PLL
// R16: PLL lock reads in status bit 0
// R17: Far transmitter ready before links enabled
// R18: Link enable 0x01 starts bring-up
// R19: Four per-lane status bytes, 0xFF when good
// R20: Ones clear latched lane interrupts
// R21: 0x00 resets recovery, 0x01 enables it
// R22: Ones clear main interrupt flags
// R23: Host disables links before configuring them
// R24: Host sets lane count and interpolation rate; no register holds them here (lanes fixed at 8)
`timescale 1ns/100ps
module link_bringup import bringup_pkg::*; (
    input  wire logic                 core_clk_i,   // 25 MHz core clock
    input  wire logic                 rst_i,        // synchronous reset
    input  wire logic                 sclk_i,       // serial clock pin
    input  wire logic                 csn_i,        // chip select, low
    input  wire logic                 mosi_i,       // serial data in
    output logic                      miso_o,       // serial data out
    output logic                      miso_oe_o,    // serial out enable
    input  wire logic                 pll_locked_i, // PLL lock, async
    input  wire logic [NUM_LANES-1:0] lane_cgs_i,   // code group sync
    input  wire logic [NUM_LANES-1:0] lane_fs_i,    // frame sync
    input  wire logic [NUM_LANES-1:0] lane_cks_i,   // checksum good
    input  wire logic [NUM_LANES-1:0] lane_ils_i,   // initial lane sync
    input  wire logic [IRQ_W-1:0]     irq_event_i,  // datapath events
    output logic                      inverse_sinc_enable_o,       // opt
    output logic                      oscillator_mix_enable_o,     // opt
    output logic                      filter_bandwidth_select_o,   // opt
    output logic                      fractional_modulus_enable_o, // opt
    output logic                      sideband_select_o,           // opt
    output logic                      half_band_interp_enable_o,   // opt
    output logic                      serdes_enable_o,  // block powered
    output logic [NUM_LANES-1:0]      lane_pd_o,        // lane power-down
    output logic                      cdr_enable_o,     // recovery on
    output logic [7:0]                cdr_rate_o,       // recovery rate
    output logic                      pll_enable_o,     // PLL on
    output logic [1:0]                pll_div_o,        // PLL divider
    output logic [1:0]                pll_ref_rate_o,   // ref clock rate
    output logic [7:0]                pll_override_o,   // PLL override
    output logic                      tcal_first_o,     // cal pulse 1
    output logic                      tcal_second_o,    // cal pulse 2
    output logic                      deframer_rst_o,   // deframer reset
    output logic                      descramble_o,     // descramble on
    output logic [2:0]                subclass_o,       // latency class
    output logic [2:0]                version_o,        // link version
    output logic [7:0]                checksum_o,       // lane 0 checksum
    output logic                      link_enable_o,    // links enabled
    output logic                      link_up_o         // link running
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOCK = 2'b01,
        ST_SYNC = 2'b11,
        ST_RUN  = 2'b10
    } link_st_t;

    typedef struct packed {
        logic [7:0]           dp;
        logic [7:0]           ref_rate;
        logic [7:0]           mpwr;
        logic [7:0]           lane_pd;
        logic [7:0]           cdr_ctl;
        logic [7:0]           cdr_rate;
        logic [7:0]           pll_ctl;
        logic [7:0]           pll_div;
        logic [7:0]           pll_ovr;
        logic [7:0]           tcal1;
        logic [7:0]           tcal2;
        logic [7:0]           link_en;
        logic [7:0]           scr;
        logic [7:0]           subcl;
        logic [7:0]           ver;
        logic [7:0]           cks;
        logic [7:0]           dfr;
        logic [IRQ_W-1:0]     irq;
        logic [7:0]           sirq1;
        logic                 sirq2;
        logic                 lock_m;
        logic                 lock_s;
        logic [4*NUM_LANES-1:0] stat_m;
        logic [4*NUM_LANES-1:0] stat_s;
        logic [NUM_LANES-1:0] cgs_p;
        logic [NUM_LANES-1:0] fs_p;
        logic                 cal1;
        logic                 cal2;
        link_st_t             st;
    } state_t;

    state_t                 q;
    state_t                 n;
    logic [ADDR_W-1:0]      addr;
    logic [DATA_W-1:0]      wdata;
    logic                   wr;
    logic [DATA_W-1:0]      rdata;
    logic                   locked;
    logic                   link_on;
    logic [NUM_LANES-1:0]   active;
    logic [NUM_LANES-1:0]   cgs;
    logic [NUM_LANES-1:0]   fs;
    logic [NUM_LANES-1:0]   cks;
    logic [NUM_LANES-1:0]   ils;

    // ====
    // Serial configuration port
    cfg_serial_port u_port (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .sclk_i     (sclk_i),
        .csn_i      (csn_i),
        .mosi_i     (mosi_i),
        .miso_o     (miso_o),
        .miso_oe_o  (miso_oe_o),
        .addr_o     (addr),
        .wdata_o    (wdata),
        .wr_o       (wr),
        .rdata_i    (rdata)
    );

    // A lane reports success only while it is powered, the link is enabled and the PLL is locked.
    function automatic logic [NUM_LANES-1:0] lane_view(
        input logic [NUM_LANES-1:0] raw,
        input logic [NUM_LANES-1:0] pd,
        input logic                 on
    );
        lane_view = raw & ~pd & {NUM_LANES{on}};
    endfunction

    function automatic logic hit(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] reg_a,
        input logic              stb
    );
        hit = stb && (a == reg_a);
    endfunction

    // ====
    // Derived conditions
    assign locked  = q.lock_s & (q.pll_ctl == PLL_ENABLE); // R16
    assign link_on = q.link_en[0]                          // R18
                   & (q.mpwr == POWER_ON)                  // R05
                   & ~q.dfr[DFR_RST_BIT]                   // R11
                   & q.cdr_ctl[0]                          // R21
                   & (q.pll_ctl == PLL_ENABLE);            // R15
    assign active  = ~q.lane_pd;                           // R12
    assign cgs = lane_view(q.stat_s[NUM_LANES-1:0], q.lane_pd,
                           link_on & locked);              // R19
    assign fs  = lane_view(q.stat_s[2*NUM_LANES-1:NUM_LANES], q.lane_pd,
                           link_on & locked);
    assign cks = lane_view(q.stat_s[3*NUM_LANES-1:2*NUM_LANES], q.lane_pd,
                           link_on & locked);
    assign ils = lane_view(q.stat_s[4*NUM_LANES-1:3*NUM_LANES], q.lane_pd,
                           link_on & locked);

    // ====
    // Read multiplexer; unmapped addresses read as zero.
    always_comb begin
        case (addr)
            A_IRQ_STATUS:  rdata = {{(8-IRQ_W){1'b0}}, q.irq};
            A_PLL_REF:     rdata = q.ref_rate;
            A_DP_OPTS:     rdata = q.dp;
            A_MASTER_PWR:  rdata = q.mpwr;
            A_LANE_PD:     rdata = q.lane_pd;
            A_CDR_CTL:     rdata = q.cdr_ctl;
            A_CDR_RATE:    rdata = q.cdr_rate;
            A_PLL_CTL:     rdata = q.pll_ctl;
            A_PLL_STAT:    rdata = {7'h00, locked};         // R16
            A_PLL_DIV:     rdata = q.pll_div;
            A_PLL_OVR:     rdata = q.pll_ovr;
            A_TCAL_FIRST:  rdata = q.tcal1;
            A_TCAL_SECOND: rdata = q.tcal2;
            A_LINK_EN:     rdata = q.link_en;
            A_SCRAMBLE:    rdata = q.scr;
            A_SUBCLASS:    rdata = q.subcl;
            A_VERSION:     rdata = q.ver;
            A_CHECKSUM:    rdata = q.cks;
            A_CGS_STAT:    rdata = cgs;                     // R19
            A_FS_STAT:     rdata = fs;                      // R19
            A_CKS_STAT:    rdata = cks;                     // R19
            A_ILS_STAT:    rdata = ils;                     // R19
            A_DFR_RESET:   rdata = q.dfr;
            A_SIRQ_FIRST:  rdata = q.sirq1;
            A_SIRQ_SECOND: rdata = {7'h00, q.sirq2};
            default:       rdata = 8'h00;
        endcase
    end

    // ====
    // Next state
    always_comb begin
        n        = q;
        n.lock_m = pll_locked_i;
        n.lock_s = q.lock_m;
        n.stat_m = {lane_ils_i, lane_cks_i, lane_fs_i, lane_cgs_i};
        n.stat_s = q.stat_m;
        n.cgs_p  = cgs;
        n.fs_p   = fs;
        n.cal1   = 1'b0;
        n.cal2   = 1'b0;

        if (wr) begin
            case (addr)
                A_PLL_REF:     n.ref_rate = wdata;          // R04
                A_DP_OPTS:     n.dp = wdata & DP_WR_MASK;   // R01
                A_MASTER_PWR:  n.mpwr = wdata;              // R05
                A_LANE_PD:     n.lane_pd = wdata;           // R12
                A_CDR_CTL:     n.cdr_ctl = wdata;           // R21
                A_CDR_RATE:    n.cdr_rate = wdata;          // R02
                A_PLL_CTL:     n.pll_ctl = wdata;           // R15
                A_PLL_DIV:     n.pll_div = wdata;           // R03
                A_PLL_OVR:     n.pll_ovr = wdata;           // R14
                A_TCAL_FIRST: begin
                    n.tcal1 = wdata;
                    n.cal1  = (wdata == CMD_ONE);           // R13
                end
                A_TCAL_SECOND: begin
                    n.tcal2 = wdata;
                    n.cal2  = (wdata == CMD_ONE);           // R13
                end
                A_LINK_EN:     n.link_en = wdata;           // R18
                A_SCRAMBLE:    n.scr = wdata;               // R07
                A_SUBCLASS:    n.subcl = wdata;             // R08
                A_VERSION:     n.ver = wdata;               // R09
                A_CHECKSUM:    n.cks = wdata;               // R10
                A_DFR_RESET:   n.dfr = wdata;               // R06
                default:       ;
            endcase
        end

        // Sticky flags: a new event in the clearing cycle survives.
        n.irq = (q.irq & ~(hit(addr, A_IRQ_STATUS, wr)
                ? wdata[IRQ_W-1:0] : {IRQ_W{1'b0}}))
              | irq_event_i;                                // R22
        n.sirq1 = (q.sirq1 & ~(hit(addr, A_SIRQ_FIRST, wr)
                  ? wdata : 8'h00))
                | (q.cgs_p & ~cgs & {NUM_LANES{q.st == ST_RUN}}); // R20
        n.sirq2 = (q.sirq2 & ~(hit(addr, A_SIRQ_SECOND, wr) & wdata[0]))
                | (|(q.fs_p & ~fs) & (q.st == ST_RUN));     // R20

        // Bring-up sequence; any loss of enables or lock drops it to idle.
        case (q.st)
            ST_IDLE: begin
                if (link_on) begin
                    n.st = ST_LOCK;                         // R18
                end
            end
            ST_LOCK: begin
                if (!link_on) begin
                    n.st = ST_IDLE;
                end else if (locked) begin
                    n.st = ST_SYNC;                         // R16
                end
            end
            ST_SYNC: begin
                if (!link_on || !locked) begin
                    n.st = ST_IDLE;
                end else if (cgs == active && ils == active) begin
                    n.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!link_on || !locked) begin
                    n.st = ST_IDLE;
                end else if (cgs != active) begin
                    n.st = ST_SYNC;
                end
            end
            default: n.st = ST_IDLE;
        endcase
    end

    // ====
    // State register
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            q      <= '0;
            q.mpwr <= RST_MASTER;
            q.dfr  <= RST_DFR;
            q.st   <= ST_IDLE;
        end else begin
            q <= n;
        end
    end

    // ====
    // Outputs
    assign inverse_sinc_enable_o       = q.dp[DP_INVSINC];
    assign oscillator_mix_enable_o     = q.dp[DP_OSC];
    assign filter_bandwidth_select_o   = q.dp[DP_FILTER_BANDWIDTH_SELECT];
    assign fractional_modulus_enable_o = q.dp[DP_MODULUS];
    assign sideband_select_o           = q.dp[DP_SIDEBAND];
    assign half_band_interp_enable_o   = q.dp[DP_HB_INTERP];
    assign serdes_enable_o  = (q.mpwr == POWER_ON);            // R05
    assign lane_pd_o        = q.lane_pd;                       // R12
    assign cdr_enable_o     = q.cdr_ctl[0];                    // R21
    assign cdr_rate_o       = q.cdr_rate;
    assign pll_enable_o     = (q.pll_ctl == PLL_ENABLE);       // R15
    assign pll_div_o        = q.pll_div[1:0];
    assign pll_ref_rate_o   = q.ref_rate[FLD2_LSB+1:FLD2_LSB];
    assign pll_override_o   = q.pll_ovr;
    assign tcal_first_o     = q.cal1;
    assign tcal_second_o    = q.cal2;
    assign deframer_rst_o   = q.dfr[DFR_RST_BIT];              // R06
    assign descramble_o     = q.scr[SCRAMBLE_BIT];             // R07
    assign subclass_o       = q.subcl[FLD3_LSB+2:FLD3_LSB];    // R08
    assign version_o        = q.ver[FLD3_LSB+2:FLD3_LSB];
    assign checksum_o       = q.cks;
    assign link_enable_o    = q.link_en[0];
    assign link_up_o        = (q.st == ST_RUN);
endmodule
